/* design/spem_top.sv */
/*
 Parameter bank and error memory of a servo drive: simulation resolution,
 encoder position setting, quadrature encoder simulation and error log.
 Assumes one clock, synchronous inputs and one-cycle request strobes.
*/
`timescale 1ns/100ps
`include "spem_regs.svh"
module spem_top #(
    parameter int DEPTH = 16,
    parameter int SEC_CYCLES = `SPEM_SECOND_CYCLES
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic PAR_WR,
    input wire logic PAR_RD,
    input wire logic [15:0] PAR_ADDR,
    input wire logic [15:0] PAR_WDATA,
    output logic [15:0] PAR_RDATA,
    output logic PAR_ACK,
    output logic PAR_ERR,
    input wire logic SWITCH_ON,
    input wire logic SIM_STEP,
    input wire logic SIM_DIR,
    output logic SIM_A,
    output logic SIM_B,
    output logic SIM_INDEX,
    output logic [15:0] ACTIVE_SIM_RES,
    output logic [15:0] ACTIVE_ENC_POS,
    input wire logic AMP_ENABLE,
    input wire logic ERR_LOG,
    input wire logic [15:0] ERR_NUMBER,
    input wire spem_pkg::spem_class_t ERR_CLASS
);
    import spem_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam int PW = $clog2(SEC_CYCLES);

    spem_entry_t mem [DEPTH];
    spem_state_t state, next_state;
    logic [15:0] res_pend, next_res_pend, pos_pend, next_pos_pend;
    logic [15:0] next_rdata;
    logic next_ack, next_err;
    logic [AW:0] used, next_used, rd_idx, next_rd_idx;
    logic [AW-1:0] wr_ptr, next_wr_ptr, erase_idx, next_erase_idx, oldest;
    spem_entry_t hold, next_hold, rd_entry, wr_entry;
    logic mem_we;
    logic [AW-1:0] mem_waddr;
    logic amp_prev, next_amp_prev;
    logic [15:0] amp_cnt, next_amp_cnt, time_s, next_time_s;
    logic [PW-1:0] presc, next_presc;

    // Bus, parameters and error memory
    always_comb begin
        next_state = state;
        next_res_pend = res_pend;
        next_pos_pend = pos_pend;
        next_used = used;
        next_rd_idx = rd_idx;
        next_wr_ptr = wr_ptr;
        next_erase_idx = erase_idx;
        next_hold = hold;
        next_rdata = PAR_RDATA;
        next_ack = 1'b0;
        next_err = 1'b0;
        mem_we = 1'b0;
        mem_waddr = wr_ptr;
        wr_entry = '0;
        oldest = wr_ptr - used[AW-1:0];
        rd_entry = mem[oldest + rd_idx[AW-1:0]];
        // Logging is suspended while erasing so no half-cleared log survives
        if (ERR_LOG && state == SPEM_IDLE) begin
            mem_we = 1'b1;
            wr_entry.number = ERR_NUMBER;
            wr_entry.err_class = ERR_CLASS;
            wr_entry.amp_cycles = amp_cnt;
            wr_entry.amp_time = time_s;
            next_wr_ptr = wr_ptr + 1'b1;
            if (used != DEPTH[AW:0]) begin
                next_used = used + 1'b1;
            end
        end
        if (state == SPEM_ERASE) begin
            mem_we = 1'b1;
            mem_waddr = erase_idx;
            next_erase_idx = erase_idx + 1'b1;
            if (erase_idx == AW'(DEPTH - 1)) begin
                next_state = SPEM_IDLE;
                next_used = '0;
                next_rd_idx = '0;
                next_wr_ptr = '0;
                next_hold = '0;
            end
        end
        if (PAR_WR) begin
            next_ack = 1'b1;
            unique case (PAR_ADDR)
                `SPEM_ADDR_SIM_RES: begin
                    if (PAR_WDATA >= `SPEM_SIM_RES_MIN) begin
                        next_res_pend = PAR_WDATA;
                    end else begin
                        next_err = 1'b1;
                    end
                end
                `SPEM_ADDR_ENC_POS: begin
                    if (PAR_WDATA < 16'(`SPEM_POS_PER_REV)) begin
                        next_pos_pend = PAR_WDATA;
                    end else begin
                        next_err = 1'b1;
                    end
                end
                `SPEM_ADDR_ERASE: begin
                    if (PAR_WDATA == `SPEM_CMD_ONE && state == SPEM_IDLE) begin
                        next_state = SPEM_ERASE;
                        next_erase_idx = '0;
                    end
                end
                `SPEM_ADDR_RPTR_RST: begin
                    if (PAR_WDATA == `SPEM_CMD_ONE && state == SPEM_IDLE) begin
                        next_rd_idx = '0;
                    end
                end
                default: next_err = 1'b1;
            endcase
        end else if (PAR_RD) begin
            next_ack = 1'b1;
            next_rdata = 16'h0000;
            unique case (PAR_ADDR)
                `SPEM_ADDR_SIM_RES: next_rdata = res_pend;
                `SPEM_ADDR_ENC_POS: next_rdata = pos_pend;
                `SPEM_ADDR_ERASE: begin
                    next_rdata = {15'h0000, state == SPEM_ERASE};
                end
                `SPEM_ADDR_RPTR_RST: next_rdata = 16'h0000;
                `SPEM_ADDR_ERR_NUM: begin
                    // Past the newest entry the pointer stops, the held entry clears and reads zero
                    if (rd_idx < used && state == SPEM_IDLE) begin
                        next_hold = rd_entry;
                        next_rd_idx = rd_idx + 1'b1;
                        next_rdata = rd_entry.number;
                    end else begin
                        next_hold = '0;
                    end
                end
                `SPEM_ADDR_ERR_CLASS: next_rdata = {13'h0000, hold.err_class};
                `SPEM_ADDR_AMP_CYC: next_rdata = hold.amp_cycles;
                `SPEM_ADDR_AMP_TIME: next_rdata = hold.amp_time;
                default: next_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            state <= SPEM_IDLE;
            res_pend <= `SPEM_SIM_RES_RESET;
            pos_pend <= `SPEM_ENC_POS_RESET;
            used <= '0;
            rd_idx <= '0;
            wr_ptr <= '0;
            erase_idx <= '0;
            hold <= '0;
            PAR_RDATA <= 16'h0000;
            PAR_ACK <= 1'b0;
            PAR_ERR <= 1'b0;
        end else begin
            state <= next_state;
            res_pend <= next_res_pend;
            pos_pend <= next_pos_pend;
            used <= next_used;
            rd_idx <= next_rd_idx;
            wr_ptr <= next_wr_ptr;
            erase_idx <= next_erase_idx;
            hold <= next_hold;
            PAR_RDATA <= next_rdata;
            PAR_ACK <= next_ack;
            PAR_ERR <= next_err;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (mem_we) begin
            mem[mem_waddr] <= wr_entry;
        end
    end

    // Amplifier enable count and time since enable

    always_comb begin
        next_amp_prev = AMP_ENABLE;
        next_amp_cnt = amp_cnt;
        next_time_s = time_s;
        next_presc = presc + 1'b1;
        if (AMP_ENABLE && !amp_prev) begin
            // Saturate rather than wrap so a count never reads small again
            if (amp_cnt != 16'hffff) begin
                next_amp_cnt = amp_cnt + 1'b1;
            end
            next_time_s = 16'h0000;
            next_presc = '0;
        end else if (presc == PW'(SEC_CYCLES - 1)) begin
            next_presc = '0;
            if (time_s != 16'hffff) begin
                next_time_s = time_s + 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            amp_prev <= 1'b0;
            amp_cnt <= 16'h0000;
            time_s <= 16'h0000;
            presc <= '0;
        end else begin
            amp_prev <= next_amp_prev;
            amp_cnt <= next_amp_cnt;
            time_s <= next_time_s;
            presc <= next_presc;
        end
    end

    // Encoder simulation; settings move in only at switch-on
    logic [15:0] sim_cnt, next_sim_cnt, next_act_res, next_act_pos;
    logic [15:0] idx_point;
    logic next_sim_a, next_sim_b, next_sim_index;

    always_comb begin
        next_act_res = ACTIVE_SIM_RES;
        next_act_pos = ACTIVE_ENC_POS;
        next_sim_cnt = sim_cnt;
        if (SWITCH_ON) begin
            next_act_res = res_pend;
            next_act_pos = pos_pend;
            // Loading the position moves where the index pulse falls
            next_sim_cnt = (pos_pend < res_pend) ? pos_pend : 16'h0000;
        end else if (SIM_STEP) begin
            if (SIM_DIR) begin
                next_sim_cnt = (sim_cnt >= ACTIVE_SIM_RES - 1'b1) ?
                    16'h0000 : sim_cnt + 1'b1;
            end else begin
                next_sim_cnt = (sim_cnt == 16'h0000) ?
                    ACTIVE_SIM_RES - 1'b1 : sim_cnt - 1'b1;
            end
        end
        // Index follows the resolution in force after this edge, switch-on too
        idx_point = (next_act_res[1:0] == 2'b00) ? 16'h0002 : 16'h0000;
        next_sim_a = next_sim_cnt[1] ^ next_sim_cnt[0];
        next_sim_b = next_sim_cnt[1];
        next_sim_index = (next_sim_cnt == idx_point);
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            ACTIVE_SIM_RES <= `SPEM_SIM_RES_RESET;
            ACTIVE_ENC_POS <= `SPEM_ENC_POS_RESET;
            sim_cnt <= 16'h0000;
            SIM_A <= 1'b0;
            SIM_B <= 1'b0;
            SIM_INDEX <= 1'b0;
        end else begin
            ACTIVE_SIM_RES <= next_act_res;
            ACTIVE_ENC_POS <= next_act_pos;
            sim_cnt <= next_sim_cnt;
            SIM_A <= next_sim_a;
            SIM_B <= next_sim_b;
            SIM_INDEX <= next_sim_index;
        end
    end

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    property p_res_wait;
        !SWITCH_ON |=> ACTIVE_SIM_RES == $past(ACTIVE_SIM_RES);
    endproperty
    a_res_wait: assert property (p_res_wait)
        else $error("res changed early");

    property p_pos_wait;
        SWITCH_ON |=> ACTIVE_ENC_POS == $past(pos_pend);
    endproperty
    a_pos_wait: assert property (p_pos_wait)
        else $error("pos not applied");

    property p_res_range;
        res_pend >= `SPEM_SIM_RES_MIN;
    endproperty
    a_res_range: assert property (p_res_range)
        else $error("res below 8");

    property p_pos_range;
        pos_pend < 16'(`SPEM_POS_PER_REV);
    endproperty
    a_pos_range: assert property (p_pos_range) else $error("pos range");

    property p_index_ab;
        SIM_INDEX && ACTIVE_SIM_RES[1:0] == 2'b00 |-> SIM_A && SIM_B;
    endproperty
    a_index_ab: assert property (p_index_ab)
        else $error("index not at A,B");

    property p_erase_done;
        state == SPEM_IDLE ##1 state == SPEM_ERASE
            |-> ##[1:16] state == SPEM_IDLE && used == '0;
    endproperty
    a_erase_done: assert property (p_erase_done)
        else $error("erase hang");

    property p_read_adv;
        PAR_RD && !PAR_WR && PAR_ADDR == `SPEM_ADDR_ERR_NUM && rd_idx < used
            && state == SPEM_IDLE |=> rd_idx == $past(rd_idx) + 1'b1
            && PAR_RDATA == hold.number;
    endproperty
    a_read_adv: assert property (p_read_adv) else $error("no advance");

    property p_rptr;
        PAR_WR && PAR_ADDR == `SPEM_ADDR_RPTR_RST && PAR_WDATA == `SPEM_CMD_ONE
            && state == SPEM_IDLE && next_state == SPEM_IDLE |=> rd_idx == '0;
    endproperty
    a_rptr: assert property (p_rptr) else $error("pointer not reset");

    property p_amp_cnt;
        AMP_ENABLE && !amp_prev && amp_cnt != 16'hffff
            |=> amp_cnt == $past(amp_cnt) + 1'b1 && time_s == 16'h0000;
    endproperty
    a_amp_cnt: assert property (p_amp_cnt)
        else $error("enable count");
endmodule // spem_top

/* design/spem_regs.svh */
/*
 Parameter addresses, reset values, value ranges and timing counts of the
 servo parameter and error memory block.
 Assumes a master that issues 16-bit parameter reads and writes by address.
*/
// Operation
// - A written encoder position takes effect only at the next switch-on.
// - A new encoder position also moves the virtual and simulated index.
// - A singleturn position runs from zero to one below 16384 per revolution.
// - Simulation resolution: unsigned 16 bits, 8 to 65535, default 4096.
// - With resolution divisible by four the index pulse is at A and B high.
// - A changed resolution takes effect only at the next power-on.
// - Each error entry keeps the 16-bit count of amplifier enables before it.
// - Each error entry keeps the 16-bit seconds from last enable to it.
// - Error classes 0 to 4 run from warning to non-resettable fatal.
// - Writing one to the erase command clears every error entry.
// - The erase command reads zero when clearing is done; the master polls.
// - Reading the error number latches its entry and advances the pointer.
// - Writing one to the pointer reset points reads at the oldest entry.
`ifndef SPEM_REGS_SVH
`define SPEM_REGS_SVH
`define SPEM_ADDR_SIM_RES 16'h052a
`define SPEM_ADDR_ENC_POS 16'h052c
`define SPEM_ADDR_ERASE 16'h3b08
`define SPEM_ADDR_RPTR_RST 16'h3b0a
`define SPEM_ADDR_ERR_NUM 16'h3c02
`define SPEM_ADDR_ERR_CLASS 16'h3c04
`define SPEM_ADDR_AMP_CYC 16'h3c0a
`define SPEM_ADDR_AMP_TIME 16'h3c0c
`define SPEM_SIM_RES_RESET 16'h1000
`define SPEM_SIM_RES_MIN 16'h0008
`define SPEM_ENC_POS_RESET 16'h0000
`define SPEM_POS_PER_REV 16384
`define SPEM_CMD_ONE 16'h0001
`define SPEM_SECOND_US 1000000
`define SPEM_CLOCK_MHZ 40
`define SPEM_SECOND_CYCLES (`SPEM_SECOND_US * `SPEM_CLOCK_MHZ)
`endif

/* design/spem_pkg.sv */
/*
 Types of the servo parameter and error memory block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package spem_pkg;
    typedef enum logic [2:0] {
        SPEM_CLS_WARNING = 3'h0,
        SPEM_CLS_QSTOP_7 = 3'h1,
        SPEM_CLS_QSTOP_89 = 3'h2,
        SPEM_CLS_FATAL_RES = 3'h3,
        SPEM_CLS_FATAL_PERM = 3'h4
    } spem_class_t;
    typedef enum logic [1:0] {
        SPEM_IDLE = 2'b01,
        SPEM_ERASE = 2'b10
    } spem_state_t;
    typedef struct packed {
        logic [15:0] number;
        spem_class_t err_class;
        logic [15:0] amp_cycles;
        logic [15:0] amp_time;
    } spem_entry_t;
endpackage

/* tb/spem_master.sv */
/*
 Fieldbus master model issuing one-cycle parameter read and write strobes.
 Assumes the block acknowledges every strobe one clock later.
*/
`timescale 1ns/100ps
module spem_master (
    input wire logic clock,
    output logic par_wr,
    output logic par_rd,
    output logic [15:0] par_addr,
    output logic [15:0] par_wdata,
    input wire logic [15:0] par_rdata,
    input wire logic par_ack,
    input wire logic par_err
);
    initial begin
        par_wr = 1'b0;
        par_rd = 1'b0;
        par_addr = 16'hffff;
        par_wdata = 16'hffff;
    end
    // No direction inversion exists here, so nothing precedes a position
    // Power is never removed, so the one-second hold is kept trivially
    task automatic xfer(input logic w, input logic [15:0] a,
            input logic [15:0] d, output logic [15:0] q,
            output logic e, output logic k);
        @(negedge clock);
        par_wr = w;
        par_rd = ~w;
        par_addr = a;
        par_wdata = d;
        @(negedge clock);
        par_wr = 1'b0;
        par_rd = 1'b0;
        // Released lines show the inverse so stale values cannot pass
        par_addr = ~a;
        par_wdata = ~d;
        q = par_rdata;
        e = par_err;
        k = par_ack;
    endtask
endmodule // spem_master

/* tb/spem_top_bench.sv */
/*
 Self-checking bench of the parameter bank and error memory.
 Assumes a shortened second of 10 cycles and an eight-entry log.
*/
`timescale 1ns/100ps
`include "spem_regs.svh"
module spem_top_bench;
    import spem_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic par_wr, par_rd, par_ack, par_err;
    logic [15:0] par_addr, par_wdata, par_rdata;
    logic switch_on = 1'b0;
    logic sim_step = 1'b0;
    logic sim_dir = 1'b1;
    logic sim_a, sim_b, sim_index;
    logic [15:0] active_sim_res, active_enc_pos;
    logic amp_enable = 1'b0;
    logic err_log = 1'b0;
    logic [15:0] err_number = 16'h0000;
    spem_class_t err_class = SPEM_CLS_WARNING;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #12.5 clock = ~clock;

    spem_top #(.DEPTH(8), .SEC_CYCLES(10)) dut (.CLOCK(clock), .NRST(nrst),
        .PAR_WR(par_wr), .PAR_RD(par_rd), .PAR_ADDR(par_addr),
        .PAR_WDATA(par_wdata), .PAR_RDATA(par_rdata), .PAR_ACK(par_ack),
        .PAR_ERR(par_err), .SWITCH_ON(switch_on), .SIM_STEP(sim_step),
        .SIM_DIR(sim_dir), .SIM_A(sim_a), .SIM_B(sim_b),
        .SIM_INDEX(sim_index), .ACTIVE_SIM_RES(active_sim_res),
        .ACTIVE_ENC_POS(active_enc_pos), .AMP_ENABLE(amp_enable),
        .ERR_LOG(err_log), .ERR_NUMBER(err_number), .ERR_CLASS(err_class));

    spem_master master (.clock(clock), .par_wr(par_wr), .par_rd(par_rd),
        .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
        .par_ack(par_ack), .par_err(par_err));

    task automatic chk(input string name, input logic [15:0] exp,
            input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic acc(input logic w, input logic [15:0] a, d,
            input logic bad);
        logic [15:0] q;
        logic e, k;
        master.xfer(w, a, d, q, e, k);
        chk("ack", 16'h0001, {15'h0000, k});
        chk("err", {15'h0000, bad}, {15'h0000, e});
        if (!w && !bad) begin
            chk("rdata", d, q);
        end
    endtask

    task automatic steps(input int n);
        repeat (n) begin
            @(negedge clock);
            sim_step = 1'b1;
        end
        @(negedge clock);
        sim_step = 1'b0;
    endtask

    task automatic power_on;
        @(negedge clock);
        switch_on = 1'b1;
        @(negedge clock);
        switch_on = 1'b0;
    endtask

    task automatic t_defaults;
        chk("active_res", `SPEM_SIM_RES_RESET, active_sim_res);
        chk("active_pos", 16'h0000, active_enc_pos);
        acc(1'b0, `SPEM_ADDR_SIM_RES, `SPEM_SIM_RES_RESET, 1'b0);
        acc(1'b0, 16'h0100, 16'h0000, 1'b1);
    endtask

    task automatic t_resolution;
        acc(1'b1, `SPEM_ADDR_SIM_RES, 16'h0007, 1'b1);
        acc(1'b1, `SPEM_ADDR_SIM_RES, 16'hffff, 1'b0);
        acc(1'b0, `SPEM_ADDR_SIM_RES, 16'hffff, 1'b0);
        acc(1'b1, `SPEM_ADDR_SIM_RES, 16'h0008, 1'b0);
        acc(1'b1, `SPEM_ADDR_ENC_POS, 16'h4000, 1'b1);
        acc(1'b1, `SPEM_ADDR_ENC_POS, 16'h3fff, 1'b0);
        acc(1'b1, `SPEM_ADDR_ENC_POS, 16'h0002, 1'b0);
        chk("active_res", 16'h1000, active_sim_res);
        chk("active_pos", 16'h0000, active_enc_pos);
        power_on;
        chk("active_res", 16'h0008, active_sim_res);
        chk("active_pos", 16'h0002, active_enc_pos);
        // A full turn of eight steps returns to the position just loaded
        steps(8);
        chk("index", 16'h0001, {15'h0000, sim_index});
        chk("a", 16'h0001, {15'h0000, sim_a});
        chk("b", 16'h0001, {15'h0000, sim_b});
        // One step down leaves the index and shows the quadrature order
        sim_dir = 1'b0;
        steps(1);
        chk("index", 16'h0000, {15'h0000, sim_index});
        chk("a", 16'h0001, {15'h0000, sim_a});
        chk("b", 16'h0000, {15'h0000, sim_b});
        sim_dir = 1'b1;
        acc(1'b1, `SPEM_ADDR_SIM_RES, 16'h0009, 1'b0);
        power_on;
        chk("active_res", 16'h0009, active_sim_res);
        steps(9);
        chk("index", 16'h0000, {15'h0000, sim_index});
    endtask

    task automatic t_log;
        amp_enable = 1'b1;
        repeat (2) @(negedge clock);
        amp_enable = 1'b0;
        repeat (2) @(negedge clock);
        amp_enable = 1'b1;
        // Logging 22 to 26 cycles after the enable keeps the time at 2 s
        repeat (22) @(negedge clock);
        for (int i = 0; i < 5; i++) begin
            err_number = 16'h0010 + i[15:0];
            err_class = spem_class_t'(i[2:0]);
            err_log = 1'b1;
            @(negedge clock);
        end
        err_log = 1'b0;
        amp_enable = 1'b0;
        @(negedge clock);
        amp_enable = 1'b1;
        repeat (12) @(negedge clock);
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, `SPEM_ADDR_ERR_NUM, 16'h0010 + i[15:0], 1'b0);
            acc(1'b0, `SPEM_ADDR_ERR_CLASS, {13'h0000, i[2:0]}, 1'b0);
            acc(1'b0, `SPEM_ADDR_AMP_CYC, 16'h0002, 1'b0);
            acc(1'b0, `SPEM_ADDR_AMP_TIME, 16'h0002, 1'b0);
        end
        acc(1'b0, `SPEM_ADDR_ERR_NUM, 16'h0000, 1'b0);
        acc(1'b1, `SPEM_ADDR_RPTR_RST, `SPEM_CMD_ONE, 1'b0);
        acc(1'b0, `SPEM_ADDR_ERR_NUM, 16'h0010, 1'b0);
    endtask

    task automatic t_erase;
        logic [15:0] q;
        logic e, k;
        int n;
        acc(1'b1, `SPEM_ADDR_ERASE, `SPEM_CMD_ONE, 1'b0);
        acc(1'b0, `SPEM_ADDR_ERASE, 16'h0001, 1'b0);
        n = 0;
        q = 16'h0001;
        while (q !== 16'h0000 && n < 20) begin
            master.xfer(1'b0, `SPEM_ADDR_ERASE, 16'h0000, q, e, k);
            n++;
        end
        chk("erase_done", 16'h0000, q);
        acc(1'b1, `SPEM_ADDR_RPTR_RST, `SPEM_CMD_ONE, 1'b0);
        acc(1'b0, `SPEM_ADDR_ERR_NUM, 16'h0000, 1'b0);
    endtask

    task automatic final_report;
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // The whole run takes well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            final_report;
        end
    end

    initial begin
        repeat (12) @(negedge clock);
        nrst = 1'b1;
        t_defaults;
        t_resolution;
        t_log;
        t_erase;
        final_report;
    end
endmodule // spem_top_bench
